// ==== core/video_rx_cfg_pkg.sv ====
// Purpose: constants and carriers for the receiver processing control words
// Assumes: one clock domain, 16-bit register words at word addresses
// Notes:   bit positions and reset values of both control words
`default_nettype none

package video_rx_cfg_pkg;
    localparam int unsigned REG_WIDTH = 16;
    localparam int unsigned ADDR_WIDTH = 12;
    localparam logic [11:0] ADDR_CTRL_A = 12'h000;
    localparam logic [11:0] ADDR_CTRL_B = 12'h001;

    // first control word fields
    localparam int unsigned A_REMAP_OFF = 14;
    localparam int unsigned A_EDH_FREEZE = 12;
    localparam int unsigned A_EDH_INS_OFF = 11;
    localparam int unsigned A_BLANK_SEL = 10;
    localparam int unsigned A_ANC_EXT_OFF = 9;
    localparam int unsigned A_PIN_OVR = 7;
    localparam int unsigned A_TIM_FMT = 6;
    localparam int unsigned A_BAD_REMAP_OFF = 4;
    localparam int unsigned A_ANC_SUM_OFF = 3;
    localparam int unsigned A_LINE_CHK_OFF = 2;
    localparam int unsigned A_LINE_NUM_OFF = 1;
    localparam int unsigned A_SYNC_INS_OFF = 0;
    // bit 15 reads zero; 13, 8 and 5 are reserved but writable
    localparam logic [15:0] CTRL_A_WMASK = 16'h7FFF;
    localparam logic [15:0] CTRL_A_RESET = 16'h0000;

    // second control word, upper part
    localparam int unsigned B_PLAIN_POL = 14;
    localparam int unsigned B_AUTODET_OFF = 13;
    localparam int unsigned B_REMAP_OFF2 = 12;
    localparam int unsigned B_REGEN_OFF = 10;
    localparam int unsigned B_SWAP = 9;
    localparam int unsigned B_LVL_CONV_OFF = 8;
    localparam logic [15:0] CTRL_B_WMASK = 16'hFFFF;
    localparam logic [15:0] CTRL_B_RESET = 16'h0100;

    typedef struct packed {
        logic syncRemapOffS1;
        logic edhFlagFreeze;
        logic edhCheckInsertOff;
        logic ancillaryExtractOff;
        logic badCodeRemapOffS1;
        logic ancSumInsertOffS1;
        logic lineCheckInsertOffS1;
        logic lineNumberInsertOffS1;
        logic syncWordInsertOffS1;
        logic syncWordRemapOffS2;
        logic payloadIdRegenOff;
        logic levelConversionOff;
    } proc_ctrl_t;

    typedef struct packed {
        logic [9:0] firstDataStream;
        logic [9:0] secondDataStream;
    } stream_pair_t;
endpackage : video_rx_cfg_pkg

`default_nettype wire

// ==== core/video_rx_processing_config_regs.sv ====
// Purpose: processing control words and the settings they steer
// Assumes: host accesses arrive as one-cycle word strobes on mclk
// Notes:   read data is registered, valid one cycle after the read strobe
`default_nettype none

module video_rx_processing_config_regs (
    input  wire logic                              mclk,
    input  wire logic                              rstn,
    // host register port
    input  wire logic [11:0]                       regAddr,
    input  wire logic                              regWrite,
    input  wire logic                              regRead,
    input  wire logic [15:0]                       regWdata,
    output logic [15:0]                            regRdata,
    output logic                                   regRvalid,
    // timing and video status
    input  wire logic                              timing_format_pin,
    input  wire logic                              blankingActive,
    input  wire logic                              trsHBit,
    input  wire logic                              asiMode,
    input  wire logic                              polarityDetected,
    input  wire logic                              mode3g,
    input  wire logic                              levelBInput,
    input  wire logic                              ddrOutput,
    input  wire logic                              ddrPhase,
    input  wire video_rx_cfg_pkg::stream_pair_t    streamIn,
    // outputs
    output video_rx_cfg_pkg::proc_ctrl_t           procCtrl,
    output logic                                   timingCea861,
    output logic                                   hBlankOut,
    output logic                                   asiPlainDecode,
    output logic                                   levelConvertActive,
    output logic [19:0]                            parallelOut
);

    logic        rstMeta_ff;
    logic        rstSync_ff;
    logic [15:0] ctrlA_ff;
    logic [15:0] ctrlB_ff;
    logic [15:0] nxt_ctrlA;
    logic [15:0] nxt_ctrlB;
    logic [15:0] rdata_ff;
    logic [15:0] nxt_rdata;
    logic        rvalid_ff;
    logic        nxt_rvalid;
    logic        hBlank_ff;
    logic        nxt_hBlank;
    logic        plain_ff;
    logic        nxt_plain;
    logic [19:0] pout_ff;
    logic [19:0] nxt_pout;
    logic        fmtCea;

    // reset release through two flops
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rstMeta_ff <= 1'b0;
            rstSync_ff <= 1'b0;
        end else begin
            rstMeta_ff <= 1'b1;
            rstSync_ff <= rstMeta_ff;
        end
    end

    function automatic logic [15:0] mergeWrite(input logic [15:0] cur,
                                               input logic [15:0] wd,
                                               input logic [15:0] msk);
        mergeWrite = (cur & ~msk) | (wd & msk);
    endfunction : mergeWrite

    // register writes and reads
    always_comb begin
        nxt_ctrlA  = ctrlA_ff;
        nxt_ctrlB  = ctrlB_ff;
        nxt_rdata  = rdata_ff;
        nxt_rvalid = regRead;
        if (regWrite && regAddr == video_rx_cfg_pkg::ADDR_CTRL_A) begin
            nxt_ctrlA = mergeWrite(ctrlA_ff, regWdata,
                                   video_rx_cfg_pkg::CTRL_A_WMASK);
        end
        if (regWrite && regAddr == video_rx_cfg_pkg::ADDR_CTRL_B) begin
            nxt_ctrlB = mergeWrite(ctrlB_ff, regWdata,
                                   video_rx_cfg_pkg::CTRL_B_WMASK);
        end
        if (regRead) begin
            unique case (regAddr)
                video_rx_cfg_pkg::ADDR_CTRL_A: nxt_rdata = ctrlA_ff;
                video_rx_cfg_pkg::ADDR_CTRL_B: nxt_rdata = ctrlB_ff;
                default:                       nxt_rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rstSync_ff) begin
        if (!rstSync_ff) begin
            ctrlA_ff  <= video_rx_cfg_pkg::CTRL_A_RESET;
            ctrlB_ff  <= video_rx_cfg_pkg::CTRL_B_RESET;
            rdata_ff  <= 16'h0000;
            rvalid_ff <= 1'b0;
        end else begin
            ctrlA_ff  <= nxt_ctrlA;
            ctrlB_ff  <= nxt_ctrlB;
            rdata_ff  <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
        end
    end

    assign regRdata  = rdata_ff;
    assign regRvalid = rvalid_ff;

    assign procCtrl.syncRemapOffS1 = ctrlA_ff[video_rx_cfg_pkg::A_REMAP_OFF];
    assign procCtrl.edhFlagFreeze = ctrlA_ff[video_rx_cfg_pkg::A_EDH_FREEZE];
    assign procCtrl.edhCheckInsertOff =
        ctrlA_ff[video_rx_cfg_pkg::A_EDH_INS_OFF];
    assign procCtrl.ancillaryExtractOff =
        ctrlA_ff[video_rx_cfg_pkg::A_ANC_EXT_OFF];
    assign procCtrl.badCodeRemapOffS1 =
        ctrlA_ff[video_rx_cfg_pkg::A_BAD_REMAP_OFF];
    assign procCtrl.ancSumInsertOffS1 =
        ctrlA_ff[video_rx_cfg_pkg::A_ANC_SUM_OFF];
    assign procCtrl.lineCheckInsertOffS1 =
        ctrlA_ff[video_rx_cfg_pkg::A_LINE_CHK_OFF];
    assign procCtrl.lineNumberInsertOffS1 =
        ctrlA_ff[video_rx_cfg_pkg::A_LINE_NUM_OFF];
    assign procCtrl.syncWordInsertOffS1 =
        ctrlA_ff[video_rx_cfg_pkg::A_SYNC_INS_OFF];
    assign procCtrl.syncWordRemapOffS2 =
        ctrlB_ff[video_rx_cfg_pkg::B_REMAP_OFF2];
    assign procCtrl.payloadIdRegenOff =
        ctrlB_ff[video_rx_cfg_pkg::B_REGEN_OFF];
    assign procCtrl.levelConversionOff =
        ctrlB_ff[video_rx_cfg_pkg::B_LVL_CONV_OFF];

    assign fmtCea = ctrlA_ff[video_rx_cfg_pkg::A_PIN_OVR]
                  ? ctrlA_ff[video_rx_cfg_pkg::A_TIM_FMT]
                  : timing_format_pin;
    assign timingCea861 = fmtCea;

    assign levelConvertActive = mode3g && levelBInput &&
        !ctrlB_ff[video_rx_cfg_pkg::B_LVL_CONV_OFF];

    // blanking, polarity and stream ordering
    always_comb begin
        nxt_hBlank = 1'b0;
        if (!fmtCea) begin
            nxt_hBlank = ctrlA_ff[video_rx_cfg_pkg::A_BLANK_SEL]
                       ? trsHBit : blankingActive;
        end
        nxt_plain = plain_ff;
        if (asiMode) begin
            nxt_plain = ctrlB_ff[video_rx_cfg_pkg::B_AUTODET_OFF]
                      ? ctrlB_ff[video_rx_cfg_pkg::B_PLAIN_POL]
                      : !polarityDetected;
        end
        nxt_pout = {streamIn.firstDataStream, streamIn.secondDataStream};
        if (mode3g) begin
            if (ddrOutput) begin
                nxt_pout[19:10] =
                    (ddrPhase ^ ctrlB_ff[video_rx_cfg_pkg::B_SWAP])
                    ? streamIn.firstDataStream
                    : streamIn.secondDataStream;
                nxt_pout[9:0] = 10'h000;
            end else if (ctrlB_ff[video_rx_cfg_pkg::B_SWAP]) begin
                nxt_pout = {streamIn.secondDataStream,
                            streamIn.firstDataStream};
            end
        end
    end

    always_ff @(posedge mclk or negedge rstSync_ff) begin
        if (!rstSync_ff) begin
            hBlank_ff <= 1'b0;
            plain_ff  <= 1'b1;
            pout_ff   <= 20'h00000;
        end else begin
            hBlank_ff <= nxt_hBlank;
            plain_ff  <= nxt_plain;
            pout_ff   <= nxt_pout;
        end
    end

    assign hBlankOut      = hBlank_ff;
    assign asiPlainDecode = plain_ff;
    assign parallelOut    = pout_ff;

endmodule : video_rx_processing_config_regs

`default_nettype wire

// ==== tb/video_rx_host_model.sv ====
// Purpose: host controller side of the register port
// Assumes: one-cycle strobes, read answer one edge after the strobe
// Notes:   idle address and data show the inverse of the last value
`default_nettype none
module video_rx_host_model (
    output logic [11:0]      regAddr,
    output logic             regWrite,
    output logic             regRead,
    output logic [15:0]      regWdata,
    input  wire logic        mclk,
    input  wire logic [15:0] regRdata,
    input  wire logic        regRvalid
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {regAddr, regWrite, regRead, regWdata} = '0;
    end
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge mclk);
        regWrite <= 1'b0;
        regAddr <= ~a;
        regWdata <= ~d;
    endtask : wr
    task automatic rd(input logic [11:0] a, output logic [15:0] d);
        @(posedge mclk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge mclk);
        regRead <= 1'b0;
        regAddr <= ~a;
        #1;
        d = regRvalid ? regRdata : 16'hXXXX;
    endtask : rd
endmodule : video_rx_host_model
`default_nettype wire

// ==== tb/video_rx_processing_config_regs_assertions.sv ====
// Purpose: port checks of the processing control bank
// Assumes: one mclk domain
// Notes:   bound into every instance of the bank
`default_nettype none
module video_rx_processing_config_regs_assertions (
    input wire logic                         mclk,
    input wire logic                         rstn,
    input wire logic [11:0]                  regAddr,
    input wire logic                         regWrite,
    input wire logic [15:0]                  regWdata,
    input wire logic                         timing_format_pin,
    input wire logic                         blankingActive,
    input wire logic                         trsHBit,
    input wire logic                         asiMode,
    input wire logic                         mode3g,
    input wire logic                         levelBInput,
    input wire video_rx_cfg_pkg::proc_ctrl_t procCtrl,
    input wire logic                         timingCea861,
    input wire logic                         hBlankOut,
    input wire logic                         asiPlainDecode,
    input wire logic                         levelConvertActive
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    logic wrA;
    assign wrA = regWrite && regAddr == video_rx_cfg_pkg::ADDR_CTRL_A;
    sync_insert_a: assert property (
        wrA |=> procCtrl.syncWordInsertOffS1 == $past(regWdata[0]))
        else $error("sync insert mask not taken");
    edh_freeze_a: assert property (
        wrA |=> procCtrl.edhFlagFreeze == $past(regWdata[12]))
        else $error("edh freeze not taken");
    remap_off_a: assert property (
        wrA |=> procCtrl.syncRemapOffS1 == $past(regWdata[14]))
        else $error("remap disable not taken");
    fmt_register_a: assert property (
        wrA && regWdata[7] |=> timingCea861 == $past(regWdata[6]))
        else $error("timing format not from register");
    fmt_pin_a: assert property (
        wrA && !regWdata[7] |=> timingCea861 == timing_format_pin)
        else $error("timing format not from pin");
    cea_blank_a: assert property (
        $past(timingCea861) |-> !hBlankOut)
        else $error("blanking out in cea timing");
    blank_cause_a: assert property (
        hBlankOut |-> $past(blankingActive || trsHBit))
        else $error("blanking out without cause");
    asi_hold_a: assert property (
        $past(!asiMode) |-> $stable(asiPlainDecode))
        else $error("polarity changed outside asi");
    level_conv_a: assert property (
        levelConvertActive == (mode3g && levelBInput
            && !procCtrl.levelConversionOff))
        else $error("level conversion wrong");
endmodule : video_rx_processing_config_regs_assertions
bind video_rx_processing_config_regs
    video_rx_processing_config_regs_assertions u_chk (.mclk, .rstn,
    .regAddr, .regWrite, .regWdata, .timing_format_pin, .blankingActive,
    .trsHBit, .asiMode, .mode3g, .levelBInput, .procCtrl, .timingCea861,
    .hBlankOut, .asiPlainDecode, .levelConvertActive);
`default_nettype wire

// ==== tb/tb_video_rx_processing_config_regs.sv ====
// Purpose: self-checking bench for the processing control bank
// Assumes: host transfers through the host model tasks
// Notes:   one task per scenario
`default_nettype none
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin \
    error_cnt++; $display("unexpected %s exp %h got %h", n, e, a); end end
module tb_video_rx_processing_config_regs;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [9:0] S1 = 10'h2AA;
    localparam logic [9:0] S2 = 10'h155;
    logic mclk, rstn, regWrite, regRead, regRvalid, cea, hOut, plain, lvlAct;
    logic pin, blank, hBit, asi, polDet, m3g, lvlB, ddr, phase;
    logic [11:0] regAddr;
    logic [15:0] regWdata, regRdata, rd;
    logic [19:0] pOut, e;
    video_rx_cfg_pkg::stream_pair_t sIn;
    video_rx_cfg_pkg::proc_ctrl_t pc;
    int error_cnt = 0;
    int cmp_count = 0;
    video_rx_host_model u_host (.mclk, .regAddr, .regWrite, .regRead,
        .regWdata, .regRdata, .regRvalid);
    video_rx_processing_config_regs u_dut (.mclk, .rstn, .regAddr,
        .regWrite, .regRead, .regWdata, .regRdata, .regRvalid,
        .timing_format_pin(pin), .blankingActive(blank), .trsHBit(hBit),
        .asiMode(asi), .polarityDetected(polDet), .mode3g(m3g),
        .levelBInput(lvlB), .ddrOutput(ddr), .ddrPhase(phase),
        .streamIn(sIn), .procCtrl(pc), .timingCea861(cea),
        .hBlankOut(hOut), .asiPlainDecode(plain),
        .levelConvertActive(lvlAct), .parallelOut(pOut));
    task automatic settle;
        @(posedge mclk);
        #1;
    endtask : settle
    task automatic t_reset;
        u_host.rd(12'h000, rd);
        `CHK("ctrl A", 16'h0000, rd)
        u_host.rd(12'h001, rd);
        `CHK("ctrl B", 16'h0100, rd)
        u_host.rd(12'h005, rd);
        `CHK("unmapped", 16'h0000, rd)
        `CHK("ctrl bits", 12'h001, pc)
        $display("t_reset done");
    endtask : t_reset
    task automatic t_bits;
        int b[9] = '{14, 12, 11, 9, 4, 3, 2, 1, 0};
        u_host.wr(12'h000, 16'hFFFF);
        u_host.rd(12'h000, rd);
        `CHK("ctrl A full", 16'h7FFF, rd)
        for (int i = 0; i < 9; i++) begin
            u_host.wr(12'h000, 16'h0001 << b[i]);
            #1;
            `CHK("ctrl bit", (12'h800 >> i) | 12'h001, pc)
        end
        $display("t_bits done");
    endtask : t_bits
    task automatic t_timing;
        for (int i = 0; i < 32; i++) begin
            u_host.wr(12'h000, {5'h00, i[3], 2'b00, i[2], i[1], 6'h00});
            @(posedge mclk);
            pin <= i[0];
            blank <= !i[4];
            hBit <= i[4];
            settle();
            `CHK("format", i[2] ? i[1] : i[0], cea)
            `CHK("h blank", !cea && (i[3] == i[4]), hOut)
        end
        $display("t_timing done");
    endtask : t_timing
    task automatic t_asi;
        asi <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            u_host.wr(12'h001, {1'b0, i == 2, i > 1, 13'h0100});
            @(posedge mclk);
            polDet <= !i[0];
            settle();
            `CHK("plain", i > 1 ? i == 2 : i[0], plain)
        end
        asi <= 1'b0;
        $display("t_asi done");
    endtask : t_asi
    task automatic t_streams;
        sIn <= {S1, S2};
        m3g <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            u_host.wr(12'h001, {6'h00, i[0], 9'h100});
            @(posedge mclk);
            ddr <= i[1];
            phase <= i[2];
            settle();
            e = i[0] ? {S2, S1} : {S1, S2};
            if (i[1]) e = {(i[2] ^ i[0]) ? S1 : S2, 10'h000};
            `CHK("parallel", e, pOut)
        end
        $display("t_streams done");
    endtask : t_streams
    task automatic t_level;
        lvlB <= 1'b1;
        u_host.wr(12'h001, 16'h0100);
        #1;
        `CHK("convert", 1'b0, lvlAct)
        u_host.wr(12'h001, 16'h1400);
        #1;
        `CHK("convert", 1'b1, lvlAct)
        `CHK("ctrl B bits", 12'h006, pc)
        u_host.wr(12'h001, 16'h0000);
        #1;
        `CHK("ctrl B clear", 12'h000, pc)
        $display("t_level done");
    endtask : t_level
    task automatic final_report;
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    initial begin
        #100000;
        error_cnt++;
        final_report();
    end
    initial begin
        {rstn, pin, blank, hBit, asi, polDet, m3g, lvlB, ddr, phase} = '0;
        sIn = '0;
        repeat (4) @(posedge mclk);
        rstn <= 1'b1;
        repeat (3) @(posedge mclk);
        t_reset();
        t_bits();
        t_timing();
        t_asi();
        t_streams();
        t_level();
        final_report();
    end
endmodule : tb_video_rx_processing_config_regs
`default_nettype wire
